// ==== core/pdc_timer.sv ====
// Prescaled down counter with classic Wishbone register slave and expiry outputs
`timescale 1ns/1ps
module pdc_timer
(
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_wb_cyc,
  input  wire logic                      i_wb_stb,
  input  wire logic                      i_wb_we,
  input  wire logic [pdc_pkg::ADR_W-1:0] i_wb_adr,
  input  wire logic [3:0]                i_wb_sel,
  input  wire logic [31:0]               i_wb_dat,
  output logic      [31:0]               o_wb_dat,
  output logic                           o_wb_ack,
  input  wire logic                      i_emu_mode,
  input  wire logic                      i_emu_break,
  output logic                           o_expiry_output_pin,
  output logic                           o_period_expiry_interrupt
);

  logic [15:0] period_reload_value_ff;
  logic [3:0]  prescale_reload_field_ff;
  logic        halt_bit_ff;
  logic        free_run_ff;
  logic        soft_stop_ff;
  logic [3:0]  prescale_count_ff;
  logic [15:0] main_count_ff;
  logic        alt_ff;
  logic        soft_hold_ff;
  logic        pending_ff;
  logic        pin_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        emu_mode_s1_ff;
  logic        emu_mode_s2_ff;
  logic        emu_brk_s1_ff;
  logic        emu_brk_s2_ff;

  logic        wb_req;
  logic        wr_period;
  logic        wr_ctl_lo;
  logic        wr_ctl_hi;
  logic        wr_flags;
  logic        reload_strobe;
  logic        frozen;
  logic        run;
  logic        both_zero;
  logic        borrow_pre;
  logic        borrow_main;
  logic [15:0] count_control_word;
  logic [31:0] nxt_dat;

  // Pins from the debug environment are asynchronous
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      emu_mode_s1_ff <= 1'b0;
      emu_mode_s2_ff <= 1'b0;
      emu_brk_s1_ff  <= 1'b0;
      emu_brk_s2_ff  <= 1'b0;
    end
    else
    begin
      emu_mode_s1_ff <= i_emu_mode;
      emu_mode_s2_ff <= emu_mode_s1_ff;
      emu_brk_s1_ff  <= i_emu_break;
      emu_brk_s2_ff  <= emu_brk_s1_ff;
    end
  end

  // Writes land at the edge that raises ack, one access per request
  assign wb_req        = i_wb_cyc & i_wb_stb & ~ack_ff;
  assign wr_period     = wb_req & i_wb_we & (i_wb_adr == pdc_pkg::ADR_PERIOD);
  assign wr_ctl_lo     = wb_req & i_wb_we & (i_wb_adr == pdc_pkg::ADR_CONTROL) & i_wb_sel[0];
  assign wr_ctl_hi     = wb_req & i_wb_we & (i_wb_adr == pdc_pkg::ADR_CONTROL) & i_wb_sel[1];
  assign wr_flags      = wb_req & i_wb_we & (i_wb_adr == pdc_pkg::ADR_FLAGS) & i_wb_sel[0];
  assign reload_strobe = wr_ctl_lo & i_wb_dat[pdc_pkg::CTL_RELOAD];

  // Soft stop lets the running period finish before freezing
  assign frozen     = emu_brk_s2_ff & ~free_run_ff & (~soft_stop_ff | soft_hold_ff);
  assign run        = ~halt_bit_ff & ~frozen;
  assign both_zero  = (period_reload_value_ff == 16'h0000) & (prescale_reload_field_ff == 4'h0);
  // A reload strobe wins over a borrow, so the old count cannot expire while it is replaced
  assign borrow_pre = run & ~reload_strobe & (prescale_count_ff == 4'h0);
  // Both fields zero would expire every cycle; alternate to halve the rate
  assign borrow_main = borrow_pre & (main_count_ff == 16'h0000) & (~both_zero | alt_ff);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      period_reload_value_ff <= pdc_pkg::RST_PERIOD;
    else
    begin
      if (wr_period & i_wb_sel[0])
        period_reload_value_ff[7:0] <= i_wb_dat[7:0];
      if (wr_period & i_wb_sel[1])
        period_reload_value_ff[15:8] <= i_wb_dat[15:8];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      prescale_reload_field_ff <= pdc_pkg::RST_PRESCALE;
      halt_bit_ff              <= pdc_pkg::RST_HALT;
    end
    else if (wr_ctl_lo)
    begin
      prescale_reload_field_ff <= i_wb_dat[pdc_pkg::CTL_PRE_MSB:pdc_pkg::CTL_PRE_LSB];
      halt_bit_ff              <= i_wb_dat[pdc_pkg::CTL_HALT];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      free_run_ff  <= 1'b0;
      soft_stop_ff <= 1'b0;
    end
    else if (!emu_mode_s2_ff)
    begin
      free_run_ff  <= 1'b0;
      soft_stop_ff <= 1'b0;
    end
    else if (wr_ctl_hi)
    begin
      free_run_ff  <= i_wb_dat[pdc_pkg::CTL_FREE];
      soft_stop_ff <= i_wb_dat[pdc_pkg::CTL_SOFT];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      soft_hold_ff <= 1'b0;
    else if (!emu_brk_s2_ff)
      soft_hold_ff <= 1'b0;
    else if (borrow_main)
      soft_hold_ff <= 1'b1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      prescale_count_ff <= pdc_pkg::RST_COUNT_PRE;
      main_count_ff     <= pdc_pkg::RST_COUNT_MAIN;
      alt_ff            <= 1'b0;
    end
    else if (reload_strobe)
    begin
      prescale_count_ff <= i_wb_dat[pdc_pkg::CTL_PRE_MSB:pdc_pkg::CTL_PRE_LSB];
      main_count_ff     <= period_reload_value_ff;
      alt_ff            <= 1'b0;
    end
    else if (borrow_pre)
    begin
      prescale_count_ff <= prescale_reload_field_ff;
      if (main_count_ff == 16'h0000)
        main_count_ff <= period_reload_value_ff;
      else
        main_count_ff <= main_count_ff - 16'h0001;
      alt_ff <= both_zero & ~alt_ff;
    end
    else if (run)
      prescale_count_ff <= prescale_count_ff - 4'h1;
  end

  // Expiry flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      pending_ff <= 1'b0;
    else if (borrow_main)
      pending_ff <= 1'b1;
    else if (wr_flags & i_wb_dat[pdc_pkg::FLG_EXPIRY])
      pending_ff <= 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      pin_ff <= 1'b0;
    else
      pin_ff <= borrow_main;
  end

  assign count_control_word = {4'h0, soft_stop_ff, free_run_ff, prescale_count_ff,
                               1'b0, halt_bit_ff, prescale_reload_field_ff};

  always_comb
  begin
    nxt_dat = pdc_pkg::RD_UNMAPPED;
    unique case (i_wb_adr)
      pdc_pkg::ADR_PERIOD:  nxt_dat = {16'h0000, period_reload_value_ff};
      pdc_pkg::ADR_CONTROL: nxt_dat = {16'h0000, count_control_word};
      pdc_pkg::ADR_FLAGS:   nxt_dat = {28'h0000000, pending_ff, 3'h0};
      default:              nxt_dat = pdc_pkg::RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      ack_ff <= 1'b0;
      dat_ff <= pdc_pkg::RD_UNMAPPED;
    end
    else
    begin
      ack_ff <= wb_req;
      dat_ff <= (wb_req & ~i_wb_we) ? nxt_dat : pdc_pkg::RD_UNMAPPED;
    end
  end

  assign o_wb_ack                  = ack_ff;
  assign o_wb_dat                  = dat_ff;
  assign o_expiry_output_pin       = pin_ff;
  assign o_period_expiry_interrupt = pending_ff;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  pin_one_cycle_a: assert property (pin_ff |=> !pin_ff)
    else $error("expiry pulse longer than one cycle");
  reload_loads_a: assert property (reload_strobe |=> main_count_ff == $past(period_reload_value_ff)
    && prescale_count_ff == $past(i_wb_dat[3:0]))
    else $error("reload strobe did not load counters");
  strobe_reads_zero_a: assert property (wb_req && !i_wb_we && i_wb_adr == pdc_pkg::ADR_CONTROL |=>
    !dat_ff[pdc_pkg::CTL_RELOAD] && dat_ff[15:12] == 4'h0)
    else $error("strobe or reserved bits read nonzero");
  halt_holds_a: assert property (halt_bit_ff && !reload_strobe |=> $stable(main_count_ff)
    && $stable(prescale_count_ff) && !pin_ff)
    else $error("counters moved while halted");
  psc_reload_a: assert property (borrow_pre && !reload_strobe |=>
    prescale_count_ff == $past(prescale_reload_field_ff))
    else $error("prescaler not reloaded after zero");
  main_dec_a: assert property (borrow_pre && !reload_strobe && main_count_ff != 16'h0000 |=>
    main_count_ff == $past(main_count_ff) - 16'h0001)
    else $error("main count not decremented on borrow");
  expiry_flag_a: assert property (borrow_main |=> pending_ff && pin_ff)
    else $error("expiry did not raise flag and pin");
  emu_bits_zero_a: assert property (!emu_mode_s2_ff |=> !free_run_ff && !soft_stop_ff)
    else $error("emulation bits set outside emulation");
  half_rate_a: assert property (both_zero && borrow_main && !wr_period && !wr_ctl_lo |=>
    !borrow_main)
    else $error("both zero gave full rate expiry");
  flag_clear_a: assert property (wr_flags && i_wb_dat[pdc_pkg::FLG_EXPIRY] && !borrow_main |=>
    !pending_ff)
    else $error("expiry flag not cleared by software");
  halt_write_a: assert property (wr_ctl_lo |=>
    halt_bit_ff == $past(i_wb_dat[pdc_pkg::CTL_HALT]))
    else $error("halt bit not taken from write");
  period_write_a: assert property (wr_period && i_wb_sel[0] && i_wb_sel[1] |=>
    period_reload_value_ff == $past(i_wb_dat[15:0]))
    else $error("period register not written");
  live_count_a: assert property (wb_req && !i_wb_we && i_wb_adr == pdc_pkg::ADR_CONTROL |=>
    dat_ff[pdc_pkg::CTL_CNT_MSB:pdc_pkg::CTL_CNT_LSB] == $past(prescale_count_ff))
    else $error("live prescale count not returned");
  frozen_holds_a: assert property (frozen && !reload_strobe |=>
    $stable(main_count_ff) && $stable(prescale_count_ff))
    else $error("counters moved during debug stop");
  free_runs_a: assert property (emu_brk_s2_ff && free_run_ff && !halt_bit_ff |-> run)
    else $error("free run stopped at breakpoint");
  soft_finish_a: assert property (emu_brk_s2_ff && !free_run_ff && soft_stop_ff && !soft_hold_ff
    && !halt_bit_ff |-> run)
    else $error("soft stop froze before period end");
  hard_stop_a: assert property (emu_brk_s2_ff && !free_run_ff && !soft_stop_ff |-> !run)
    else $error("immediate stop kept counting");

  // Main scenarios
  expiry_seen_c: cover property (borrow_main);
  reload_seen_c: cover property (reload_strobe ##1 run);
  frozen_seen_c: cover property (frozen && !halt_bit_ff);
  soft_stop_c: cover property (emu_brk_s2_ff && soft_stop_ff && soft_hold_ff);
  half_rate_c: cover property (both_zero && borrow_main);

endmodule // pdc_timer

// ==== core/pdc_pkg.sv ====
// Package with register map, field positions and reset values of the prescaled down counter
package pdc_pkg;
  localparam int unsigned ADR_W          = 4;
  localparam logic [3:0]  ADR_PERIOD     = 4'h0;
  localparam logic [3:0]  ADR_CONTROL    = 4'h4;
  localparam logic [3:0]  ADR_FLAGS      = 4'h8;
  localparam int unsigned CTL_PRE_LSB    = 0;
  localparam int unsigned CTL_PRE_MSB    = 3;
  localparam int unsigned CTL_HALT       = 4;
  localparam int unsigned CTL_RELOAD     = 5;
  localparam int unsigned CTL_CNT_LSB    = 6;
  localparam int unsigned CTL_CNT_MSB    = 9;
  localparam int unsigned CTL_FREE       = 10;
  localparam int unsigned CTL_SOFT       = 11;
  localparam int unsigned FLG_EXPIRY     = 3;
  localparam logic [15:0] RST_PERIOD     = 16'h0000;
  localparam logic [3:0]  RST_PRESCALE   = 4'h0;
  localparam logic        RST_HALT       = 1'b1;
  localparam logic [3:0]  RST_COUNT_PRE  = 4'h0;
  localparam logic [15:0] RST_COUNT_MAIN = 16'h0000;
  localparam logic [31:0] RD_UNMAPPED    = 32'h0000_0000;
endpackage

// ==== tb/prescaled_down_counter_tb_top.sv ====
// Self-checking bench for the prescaled down counter over its register bus
`timescale 1ns/1ps
module prescaled_down_counter_tb_top;
  logic                      i_clk_sys;
  logic                      i_sys_rst;
  logic                      cyc;
  logic                      stb;
  logic                      we;
  logic [pdc_pkg::ADR_W-1:0] adr;
  logic [31:0]               wdat;
  logic [31:0]               rdat;
  logic                      ack;
  logic                      pin;
  logic                      intr;
  logic                      emu_mode;
  logic                      emu_break;
  logic [31:0]               q;
  int                        fails;
  int                        checked;
  int                        g;

  pdc_timer u_dut
  (
    .i_clk_sys                 (i_clk_sys),
    .i_sys_rst                 (i_sys_rst),
    .i_wb_cyc                  (cyc),
    .i_wb_stb                  (stb),
    .i_wb_we                   (we),
    .i_wb_adr                  (adr),
    .i_wb_sel                  (4'h3),
    .i_wb_dat                  (wdat),
    .o_wb_dat                  (rdat),
    .o_wb_ack                  (ack),
    .i_emu_mode                (emu_mode),
    .i_emu_break               (emu_break),
    .o_expiry_output_pin       (pin),
    .o_period_expiry_interrupt (intr)
  );

  initial
  begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Holds the request until ack is sampled, so slow answers are tolerated
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {16'h0000, d};
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      chk("ack", 32'h0, 32'h1);
      stop_test;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // Cycles from one pin pulse to the next; also checks the pulse is one cycle wide
  task automatic gap(output int n);
    n = 0;
    while (pin !== 1'b1 && n < 100)
    begin
      @(posedge i_clk_sys);
      n++;
    end
    @(posedge i_clk_sys);
    chk("pin_width", {31'h0, pin}, 32'h0);
    n = 1;
    while (pin !== 1'b1 && n < 100)
    begin
      @(posedge i_clk_sys);
      n++;
    end
  endtask

  // Counts expiry pulses seen over a number of cycles
  task automatic pulses(input int c, output int n);
    n = 0;
    repeat (c)
    begin
      @(posedge i_clk_sys);
      if (pin === 1'b1)
        n++;
    end
  endtask

  task automatic stop_test;
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge i_clk_sys);
    fails++;
    stop_test;
  end

  initial
  begin
    fails = 0;
    checked = 0;
    i_sys_rst = 1'b1;
    {cyc, stb, we} = 3'h0;
    {emu_mode, emu_break} = 2'h0;
    adr = 4'h0;
    wdat = 32'h0;
    repeat (5) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    wb(1'b0, pdc_pkg::ADR_PERIOD, 16'h0);
    chk("period", q, 32'h0000_0000);
    wb(1'b0, pdc_pkg::ADR_CONTROL, 16'h0);
    chk("control", q, 32'h0000_0010);
    // Reserved and emulation bits written high must read back low
    wb(1'b1, pdc_pkg::ADR_CONTROL, 16'hFC3F);
    wb(1'b0, pdc_pkg::ADR_CONTROL, 16'h0);
    chk("control", q, 32'h0000_03DF);
    wb(1'b1, pdc_pkg::ADR_PERIOD, 16'h0002);
    wb(1'b1, pdc_pkg::ADR_CONTROL, 16'h0020);
    wb(1'b0, pdc_pkg::ADR_CONTROL, 16'h0);
    chk("control", q, 32'h0000_0000);
    gap(g);
    chk("interval", g, 3);
    chk("interrupt", {31'h0, intr}, 32'h1);
    wb(1'b1, pdc_pkg::ADR_CONTROL, 16'h0030);
    wb(1'b1, pdc_pkg::ADR_FLAGS, 16'h0008);
    repeat (2) @(posedge i_clk_sys);
    chk("interrupt", {31'h0, intr}, 32'h0);
    g = 0;
    repeat (30)
    begin
      @(posedge i_clk_sys);
      if (pin !== 1'b0 || intr !== 1'b0)
        g++;
    end
    chk("halted", g, 0);
    wb(1'b0, pdc_pkg::ADR_PERIOD, 16'h0);
    chk("period", q, 32'h0000_0002);
    wb(1'b1, pdc_pkg::ADR_PERIOD, 16'h0001);
    wb(1'b1, pdc_pkg::ADR_CONTROL, 16'h0023);
    gap(g);
    chk("interval", g, 8);
    wb(1'b1, pdc_pkg::ADR_PERIOD, 16'h0000);
    wb(1'b1, pdc_pkg::ADR_CONTROL, 16'h0020);
    gap(g);
    chk("interval", g, 2);
    // Debug stop: free run counts on, immediate stop freezes, soft stop ends the period first
    emu_mode <= 1'b1;
    wb(1'b1, pdc_pkg::ADR_PERIOD, 16'h0002);
    wb(1'b1, pdc_pkg::ADR_CONTROL, 16'h0420);
    wb(1'b0, pdc_pkg::ADR_CONTROL, 16'h0);
    chk("control", q, 32'h0000_0400);
    emu_break <= 1'b1;
    gap(g);
    chk("interval", g, 3);
    wb(1'b1, pdc_pkg::ADR_CONTROL, 16'h0020);
    pulses(30, g);
    chk("stopped", g, 0);
    emu_break <= 1'b0;
    gap(g);
    chk("interval", g, 3);
    wb(1'b1, pdc_pkg::ADR_CONTROL, 16'h0830);
    emu_break <= 1'b1;
    wb(1'b1, pdc_pkg::ADR_CONTROL, 16'h0820);
    pulses(30, g);
    chk("soft_stop", g, 1);
    {emu_mode, emu_break} <= 2'h0;
    repeat (3) @(posedge i_clk_sys);
    wb(1'b0, pdc_pkg::ADR_CONTROL, 16'h0);
    chk("control", q, 32'h0000_0000);
    wb(1'b0, 4'hC, 16'h0);
    chk("unmapped", q, pdc_pkg::RD_UNMAPPED);
    stop_test;
  end
endmodule // prescaled_down_counter_tb_top
